// ==== design/swb_byte_engine.sv ====
// single wire byte write/read engine behind the command intake
`timescale 1ns/1ps
`include "swb_consts.svh"
module swb_byte_engine
    import swb_pkg::*;
(
    input wire logic clk_i, // 125 MHz system clock
    input wire logic resetn_i, // async reset, active low
    input wire logic code_valid_i, // command code byte received
    input wire logic [7:0] code_i, // received command code
    input wire logic data_valid_i, // data byte complete (LSB fell)
    input wire logic [7:0] data_i, // received data byte, bit 7 first
    input wire logic ack_fall_i, // scl fell on code acknowledge bit
    input wire logic ptr_sel_data_i, // host set pointer to read data
    input wire logic line_speed_select_i, // 1: overdrive slots
    input wire logic strong_pullup_enable_i, // strong pullup after write byte
    input wire logic active_pullup_enable_i, // active pullup on release
    input wire logic line_i, // sampled single wire level
    output logic line_o, // line drive value (always low)
    output logic line_oe_o, // high while pulling the line low
    output logic active_pullup_o, // active pullup pulse on release
    output logic strong_pullup_o, // strong pullup after a write byte
    output logic code_ack_o, // acknowledge the code byte
    output logic data_ack_o, // acknowledge the data byte
    output logic line_busy_flag_o, // slots in progress
    output logic read_ptr_o, // 0 status, 1 read data
    output logic [7:0] read_data_o // byte sampled by read-byte
);
    typedef struct packed {
        swb_state_t st;
        logic [13:0] tmr;
        logic [3:0] bitn;
        logic [7:0] sh;
        logic [7:0] rdat;
        logic busy;
        logic ptr;
        logic wr_pend;
        logic wr_ok;
        logic rd_pend;
        logic is_read;
        swb_cfg_t cfg;
        logic ack_c;
        logic ack_d;
        logic oe;
        logic act_pu;
        logic str_pu;
    } swb_st_t;

    swb_st_t s_q;
    swb_st_t s_d;
    logic in_valid;
    swb_cmd_t in_cmd;
    logic in_ready;
    logic out_valid;
    swb_cmd_t out_cmd;
    logic take;

    // slot timing in cycles for the latched speed
    function automatic logic [13:0] slot_cyc(input logic od,
            input logic [1:0] k);
        logic [31:0] v;
        v = 32'h0;
        case (k)
            2'h0: v = od ? `SWB_NS_TO_CYC(`SWB_OD_SLOT_NS)
                         : `SWB_NS_TO_CYC(`SWB_STD_SLOT_NS);
            2'h1: v = od ? `SWB_NS_TO_CYC(`SWB_OD_LOW0_NS)
                         : `SWB_NS_TO_CYC(`SWB_STD_LOW0_NS);
            2'h2: v = od ? `SWB_NS_TO_CYC(`SWB_OD_LOW1_NS)
                         : `SWB_NS_TO_CYC(`SWB_STD_LOW1_NS);
            default: v = od ? `SWB_NS_TO_CYC(`SWB_OD_SAMPLE_NS)
                            : `SWB_NS_TO_CYC(`SWB_STD_SAMPLE_NS);
        endcase
        return v[13:0];
    endfunction : slot_cyc

    // figures are in ns; the macro folds in the ps clock period

    swb_cmd_buf u_buf (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .in_valid_i(in_valid),
        .in_data_i(in_cmd),
        .in_ready_o(in_ready),
        .out_valid_o(out_valid),
        .out_data_o(out_cmd),
        .out_ready_i(take)
    );

    always_comb begin
        s_d = s_q;
        s_d.ack_c = 1'b0;
        s_d.ack_d = 1'b0;
        in_valid = 1'b0;
        in_cmd = '0;
        take = (s_q.st == SWB_IDLE) && out_valid;
        if (ptr_sel_data_i) begin
            s_d.ptr = `SWB_PTR_READ_DATA;
        end
        if (code_valid_i) begin
            s_d.wr_pend = 1'b0;
            if (code_i == `SWB_CMD_WRITE_BYTE) begin
                // a refused code also refuses its data byte
                s_d.wr_pend = 1'b1;
                s_d.wr_ok = !s_q.busy && in_ready;
                s_d.ack_c = !s_q.busy && in_ready;
                if (!s_q.busy && in_ready) begin
                    s_d.ptr = `SWB_PTR_STATUS;
                end
            end else if (code_i == `SWB_CMD_READ_BYTE) begin
                s_d.ack_c = !s_q.busy && in_ready;
                s_d.rd_pend = !s_q.busy && in_ready;
                if (!s_q.busy && in_ready) begin
                    s_d.ptr = `SWB_PTR_STATUS;
                end
            end
        end
        if (data_valid_i && s_q.wr_pend) begin
            s_d.wr_pend = 1'b0;
            s_d.ack_d = s_q.wr_ok;
            if (s_q.wr_ok) begin
                // whole byte needed before the first slot
                in_valid = 1'b1;
                in_cmd.data = data_i;
                in_cmd.is_read = 1'b0;
                s_d.busy = 1'b1;
            end
        end
        if (ack_fall_i && s_q.rd_pend) begin
            s_d.rd_pend = 1'b0;
            in_valid = 1'b1;
            // busy counts from the ack edge so it spans only the slots
            s_d.busy = 1'b1;
            in_cmd.data = 8'hFF;
            in_cmd.is_read = 1'b1;
        end
        case (s_q.st)
            SWB_IDLE: begin
                s_d.oe = 1'b0;
                s_d.act_pu = 1'b0;
                if (take) begin
                    // start two cycles after the trigger: within margin
                    s_d.st = SWB_SLOT_LOW;
                    s_d.sh = out_cmd.data;
                    s_d.is_read = out_cmd.is_read;
                    s_d.bitn = 4'h0;
                    s_d.tmr = 14'h0;
                    s_d.cfg.speed_od = line_speed_select_i;
                    s_d.cfg.strong_en = strong_pullup_enable_i;
                    s_d.cfg.active_en = active_pullup_enable_i;
                    s_d.str_pu = 1'b0;
                    s_d.oe = 1'b1;
                end
            end
            SWB_SLOT_LOW: begin
                s_d.tmr = s_q.tmr + 14'h1;
                if (s_q.tmr + 14'h1 >= slot_cyc(s_q.cfg.speed_od,
                        s_q.sh[0] ? 2'h2 : 2'h1)) begin
                    s_d.oe = 1'b0;
                    s_d.act_pu = s_q.cfg.active_en;
                    s_d.st = SWB_SLOT_REL;
                end
            end
            SWB_SLOT_REL: begin
                s_d.tmr = s_q.tmr + 14'h1;
                if (s_q.tmr == slot_cyc(s_q.cfg.speed_od, 2'h3)) begin
                    if (s_q.is_read) begin
                        s_d.rdat = {line_i, s_q.rdat[7:1]};
                    end
                end
                if (s_q.tmr + 14'h1 >= slot_cyc(s_q.cfg.speed_od, 2'h0)) begin
                    s_d.tmr = 14'h0;
                    s_d.act_pu = 1'b0;
                    s_d.sh = {1'b1, s_q.sh[7:1]};
                    s_d.bitn = s_q.bitn + 4'h1;
                    if (s_q.bitn + 4'h1 == `SWB_BITS_PER_BYTE) begin
                        s_d.st = SWB_IDLE;
                        s_d.busy = in_valid || (out_valid && !take);
                        s_d.str_pu = s_q.cfg.strong_en && !s_q.is_read;
                    end else begin
                        s_d.st = SWB_SLOT_LOW;
                        s_d.oe = 1'b1;
                    end
                end
            end
            default: s_d.st = SWB_IDLE;
        endcase
        // any new command ends a strong pullup phase
        if (code_valid_i) begin
            s_d.str_pu = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_q <= '0;
            s_q.st <= SWB_IDLE;
            s_q.rdat <= `SWB_RDATA_RESET;
            s_q.ptr <= `SWB_PTR_STATUS;
        end else begin
            s_q <= s_d;
        end
    end

    assign line_o = 1'b0;
    assign line_oe_o = s_q.oe;
    assign active_pullup_o = s_q.act_pu;
    assign strong_pullup_o = s_q.str_pu;
    assign code_ack_o = s_q.ack_c;
    assign data_ack_o = s_q.ack_d;
    assign line_busy_flag_o = s_q.busy;
    assign read_ptr_o = s_q.ptr;
    assign read_data_o = s_q.rdat;
endmodule : swb_byte_engine

// ==== design/swb_cmd_buf.sv ====
// two-entry buffer between the command intake and the slot engine
`timescale 1ns/1ps
module swb_cmd_buf
    import swb_pkg::*;
(
    input wire logic clk_i, // system clock
    input wire logic resetn_i, // async reset, active low
    input wire logic in_valid_i, // producer has a command
    input swb_cmd_t in_data_i, // command in
    output logic in_ready_o, // room for a command
    output logic out_valid_o, // a command is waiting
    output swb_cmd_t out_data_o, // oldest command
    input wire logic out_ready_i // consumer takes it
);
    typedef struct packed {
        swb_cmd_t [1:0] mem;
        logic rd;
        logic wr;
        logic [1:0] cnt;
    } swb_buf_st_t;

    swb_buf_st_t s_q;
    swb_buf_st_t s_d;
    logic push;
    logic pop;

    always_comb begin
        push = in_valid_i && (s_q.cnt != 2'h2);
        pop = out_ready_i && (s_q.cnt != 2'h0);
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wr] = in_data_i;
            s_d.wr = ~s_q.wr;
        end
        if (pop) begin
            s_d.rd = ~s_q.rd;
        end
        s_d.cnt = s_q.cnt + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign in_ready_o = (s_q.cnt != 2'h2);
    assign out_valid_o = (s_q.cnt != 2'h0);
    assign out_data_o = s_q.mem[s_q.rd];
endmodule : swb_cmd_buf

// ==== design/swb_consts.svh ====
// timing figures in ns, command codes and reset values for the byte engine
`ifndef SWB_CONSTS_SVH
`define SWB_CONSTS_SVH
`define SWB_CMD_WRITE_BYTE 8'hA5
`define SWB_CMD_READ_BYTE 8'h96
`define SWB_CLK_PERIOD_PS 8000
`define SWB_START_MAX_PS 262500
`define SWB_START_MAX_CYC ((`SWB_START_MAX_PS) / (`SWB_CLK_PERIOD_PS))
`define SWB_STD_SLOT_NS 70000
`define SWB_STD_LOW0_NS 60000
`define SWB_STD_LOW1_NS 6000
`define SWB_STD_SAMPLE_NS 15000
`define SWB_OD_SLOT_NS 10000
`define SWB_OD_LOW0_NS 7500
`define SWB_OD_LOW1_NS 1000
`define SWB_OD_SAMPLE_NS 2000
`define SWB_NS_TO_CYC(ns) (((ns) * 1000) / (`SWB_CLK_PERIOD_PS))
`define SWB_PTR_STATUS 1'b0
`define SWB_PTR_READ_DATA 1'b1
`define SWB_BITS_PER_BYTE 4'h8
`define SWB_RDATA_RESET 8'h00
`endif

// ==== design/swb_pkg.sv ====
// types shared by the single wire byte engine
package swb_pkg;
    typedef enum logic [1:0] {
        SWB_IDLE,
        SWB_SLOT_LOW,
        SWB_SLOT_REL
    } swb_state_t;

    typedef struct packed {
        logic [7:0] data;
        logic is_read;
    } swb_cmd_t;

    typedef struct packed {
        logic speed_od;
        logic strong_en;
        logic active_en;
    } swb_cfg_t;
endpackage : swb_pkg

// ==== verification/swb_props.sv ====
// port assertions for the single wire byte engine
`timescale 1ns/1ps
module swb_props (
    input wire logic clk_i, // clock
    input wire logic resetn_i, // reset
    input wire logic code_valid_i, // code in
    input wire logic [7:0] code_i, // code
    input wire logic data_valid_i, // data in
    input wire logic ack_fall_i, // code ack bit fell
    input wire logic line_speed_select_i, // speed
    input wire logic line_oe_o, // pull low
    input wire logic active_pullup_o, // active pullup
    input wire logic code_ack_o, // code ack
    input wire logic data_ack_o, // data ack
    input wire logic line_busy_flag_o, // busy
    input wire logic read_ptr_o // pointer
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    logic [16:0] bc_q;
    logic [16:0] lc_q;
    logic od_q;
    logic ref_q;
    logic rd_q;
    // ref_q remembers a refused code so its data byte stays unacked
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            bc_q <= '0;
            lc_q <= '0;
            od_q <= 1'b0;
            ref_q <= 1'b0;
            rd_q <= 1'b0;
        end else begin
            bc_q <= line_busy_flag_o ? bc_q + 17'h1 : '0;
            lc_q <= line_oe_o ? lc_q + 17'h1 : '0;
            if (!line_busy_flag_o)
                od_q <= line_speed_select_i;
            if (code_valid_i)
                ref_q <= line_busy_flag_o;
            // an accepted read code waits for its ack edge
            if (code_valid_i)
                rd_q <= (code_i == 8'h96) && !line_busy_flag_o;
            else if (ack_fall_i)
                rd_q <= 1'b0;
        end
    end
    a_code_ack: assert property (
        code_valid_i && (code_i == 8'hA5 || code_i == 8'h96) &&
        !line_busy_flag_o |=> code_ack_o) else $error("code not acked");
    a_busy_nack: assert property (
        code_valid_i && line_busy_flag_o |=> !code_ack_o)
        else $error("code acked while busy");
    a_data_nack: assert property (
        data_valid_i && ref_q |=> !data_ack_o) else $error("data acked");
    a_start_gap: assert property (
        data_ack_o |-> ##[0:30] line_oe_o) else $error("write starts late");
    a_read_start: assert property (
        ack_fall_i && rd_q |-> ##[1:31] line_oe_o)
        else $error("read starts late");
    a_act_release: assert property (
        active_pullup_o |-> !line_oe_o) else $error("pullup while low");
    a_busy_len: assert property (
        $fell(line_busy_flag_o) |-> (od_q ?
        (bc_q >= 17'h270E && bc_q <= 17'h2730) :
        (bc_q >= 17'h1116E && bc_q <= 17'h11190)))
        else $error("busy length wrong");
    a_ptr_status: assert property (
        code_ack_o |-> ##2 !read_ptr_o) else $error("pointer not status");
    a_oe_busy: assert property (
        line_oe_o |-> line_busy_flag_o) else $error("drive while idle");
    a_low_width: assert property (
        $fell(line_oe_o) |-> lc_q inside {[17'h7B:17'h7F],
        [17'h3A7:17'h3AB], [17'h2EC:17'h2F0], [17'h1D4A:17'h1D4E]})
        else $error("low pulse width wrong");
    c_refuse: cover property (code_valid_i && line_busy_flag_o);
    c_done: cover property ($fell(line_busy_flag_o));
    c_std: cover property ($fell(line_oe_o) && !od_q);
endmodule : swb_props
bind swb_byte_engine swb_props u_swb_props (.*);

// ==== verification/swb_slave_model.sv ====
// single wire slave model on the far side of the line
`timescale 1ns/1ps
module swb_slave_model (
    input wire logic clk_i, // clock
    input wire logic resetn_i, // reset
    input wire logic line_oe_i, // master pulls low
    input wire logic [7:0] rd_byte_i, // bits to answer
    input wire logic [13:0] samp_i, // sample delay
    output logic line_o, // wire level
    output logic [7:0] wr_byte_o // bits seen, first in bit 0
);
    logic [13:0] t_q;
    logic [2:0] k_q;
    logic act_q;
    logic oe_q;
    // pull-up wire: high unless either side pulls it low
    assign line_o = !(line_oe_i ||
        (act_q && t_q < 14'h1F4 && !rd_byte_i[k_q]));
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            t_q <= '0;
            k_q <= '0;
            act_q <= 1'b0;
            oe_q <= 1'b0;
            wr_byte_o <= 8'h00;
        end else begin
            oe_q <= line_oe_i;
            t_q <= t_q + 14'h1;
            if (line_oe_i && !oe_q) begin
                act_q <= 1'b1;
                t_q <= '0;
            end else if (act_q && t_q == samp_i) begin
                act_q <= 1'b0;
                k_q <= k_q + 3'h1;
                wr_byte_o <= {line_o, wr_byte_o[7:1]};
            end
        end
    end
endmodule : swb_slave_model

// ==== verification/tb.sv ====
// self-checking bench for the single wire byte engine
`timescale 1ns/1ps
module tb;
    import swb_pkg::*;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic code_valid_i = 1'b0, data_valid_i = 1'b0, ack_fall_i = 1'b0;
    logic ptr_sel_data_i = 1'b0, spd = 1'b1, bprev = 1'b0, a;
    logic strong_en = 1'b1, act_en = 1'b1, line_drv, active_pullup_o;
    int act_cnt = 0, mark = 0;
    logic line_i, line_oe_o, strong_pullup_o, code_ack_o, data_ack_o;
    logic line_busy_flag_o, read_ptr_o;
    logic [7:0] code_i = 8'h00, data_i = 8'h00, read_data_o, wr_byte;
    logic [7:0] rd_byte = 8'hFF, b;
    logic [13:0] samp = 14'h1F4;
    int fail_count = 0, comparisons = 0;
    swb_cmd_t q[$];
    swb_cmd_t e;
    always #4 clk_i = ~clk_i;
    swb_byte_engine u_swb_byte_engine (.*, .line_speed_select_i(spd),
        .strong_pullup_enable_i(strong_en), .active_pullup_enable_i(act_en),
        .line_o(line_drv));
    swb_slave_model u_swb_slave_model (.clk_i(clk_i), .resetn_i(resetn_i),
        .line_oe_i(line_oe_o), .rd_byte_i(rd_byte), .samp_i(samp),
        .line_o(line_i), .wr_byte_o(wr_byte));
    task automatic chk(input string n, input logic [7:0] s, x);
        comparisons++;
        if (s !== x) begin
            fail_count++;
            $display("Error %s expected %h seen %h", n, x, s);
        end
    endtask : chk
    task automatic stop_test();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : stop_test
    // one-cycle strobe, then an ack seen in either following cycle
    // sel: 0 code, 1 data, 2 ack edge, 3 pointer select
    task automatic pulse(input logic [1:0] sel, output logic r);
        code_valid_i = (sel == 2'h0);
        data_valid_i = (sel == 2'h1);
        ack_fall_i = (sel == 2'h2);
        ptr_sel_data_i = (sel == 2'h3);
        @(negedge clk_i);
        {code_valid_i, data_valid_i, ack_fall_i, ptr_sel_data_i} = 4'h0;
        r = sel[0] ? data_ack_o : code_ack_o;
        @(negedge clk_i);
        r = r | (sel[0] ? data_ack_o : code_ack_o);
    endtask : pulse
    task automatic send(input logic [7:0] c, d, input logic ex);
        code_i = c;
        pulse(2'h0, a);
        chk("code_ack", {7'h00, a}, {7'h00, ex});
        data_i = d;
        if (c == 8'hA5) begin
            pulse(2'h1, a);
            chk("data_ack", {7'h00, a}, {7'h00, ex});
        end else begin
            pulse(2'h2, a);
        end
        if (ex) begin
            q.push_back('{data: d, is_read: c == 8'h96});
            chk("ptr", {7'h00, read_ptr_o}, 8'h00);
        end
    endtask : send
    task automatic wait_idle();
        int n;
        n = 0;
        while (line_busy_flag_o !== 1'b0 && n < 80000) begin
            @(negedge clk_i);
            n++;
        end
        if (n >= 80000) begin
            fail_count++;
            stop_test();
        end
        repeat (2) @(negedge clk_i);
    endtask : wait_idle
    always @(negedge clk_i) begin
        bprev <= line_busy_flag_o;
        if (active_pullup_o === 1'b1)
            act_cnt <= act_cnt + 1;
        if (bprev === 1'b1 && line_busy_flag_o === 1'b0) begin
            if (q.size() == 0) begin
                chk("queue", 8'h00, 8'h01);
            end else begin
                e = q.pop_front();
                chk("byte", e.is_read ? read_data_o : wr_byte, e.data);
            end
        end
    end
    initial begin
        void'($urandom(11754));
        repeat (10) @(negedge clk_i);
        resetn_i = 1'b1;
        @(negedge clk_i);
        chk("line_o", {7'h00, line_drv}, 8'h00);
        b = 8'($urandom);
        send(8'hA5, b, 1'b1);
        send(8'hA5, ~b, 1'b0);
        send(8'h96, 8'h00, 1'b0);
        wait_idle();
        chk("strong_pu", {7'h00, strong_pullup_o}, 8'h01);
        chk("active_pu", {7'h00, act_cnt != 0}, 8'h01);
        $display("test overdrive write done");
        rd_byte = 8'($urandom);
        send(8'h96, rd_byte, 1'b1);
        chk("strong_pu", {7'h00, strong_pullup_o}, 8'h00);
        wait_idle();
        rd_byte = 8'hFF;
        pulse(2'h3, a);
        chk("ptr", {7'h00, read_ptr_o}, 8'h01);
        $display("test overdrive read done");
        spd = 1'b0;
        strong_en = 1'b0;
        act_en = 1'b0;
        samp = 14'hBB8;
        b = 8'($urandom);
        mark = act_cnt;
        send(8'hA5, b, 1'b1);
        wait_idle();
        chk("strong_pu", {7'h00, strong_pullup_o}, 8'h00);
        chk("active_pu", {7'h00, act_cnt != mark}, 8'h00);
        $display("test standard write done");
        stop_test();
    end
endmodule : tb
